//--- logic/tmr3_regs.svh
// Register indices, field positions, reset values and limits of the third timer.
// Function
// - Count is two cascaded bytes, low byte carrying into high byte.
// - Counter select clear counts peripheral clock; set counts count pin falling edges.
// - Run bit gates counting; clearing it stops the timer.
// - Either serial clock select forces auto-reload on overflow, ignoring capture select.
// - Capture select and trigger enable set: trigger pin falling edge captures.
// - Capture select clear: reload on overflow, and on trigger edge if enabled.
// - Trigger pin ignored unless enabled and timer not clocking the serial port.
// - Trigger edge sets external flag; interrupts only with down-count enable clear; software clears.
// - Overflow flag set only with both serial selects clear; software clears it.
// - Serial selects route this overflow instead of the other timer's as clocks.
// - Up/down with direction high counts up; overflow sets flag, loads reload.
// - Direction low counts down; count equal reload underflows, flags, loads FFFFh.
// - Up/down mode toggles external flag on every wrap, never interrupting.
// - Clock-out drives 50% square wave on count pin, reloading each overflow.
// - Clock-out increments at half peripheral clock: f / (4 x (65536 - reload)).
// - Clock-out mode raises no interrupts from timer overflows.
// - Baud generation and clock-out may run together from shared reload registers.
// - Control register resets to zero and supports single-bit writes.
// - Down-count enable turns auto-reload into up/down counting.
// - Output enable turns count pin into the clock output.
`ifndef TMR3_REGS_SVH
`define TMR3_REGS_SVH
`define TMR3_ADDR_W       12
`define TMR3_IDX_CTRL     10'h0C8
`define TMR3_IDX_MODE     10'h0C9
`define TMR3_IDX_CNT_LO   10'h0CA
`define TMR3_IDX_CNT_HI   10'h0CB
`define TMR3_IDX_RLD_LO   10'h0CC
`define TMR3_IDX_RLD_HI   10'h0CD
`define TMR3_IDX_BITOP    10'h0CE
`define TMR3_CTRL_RESET   8'h00
`define TMR3_MODE_RESET   2'h0
`define TMR3_CTRL_TF      7
`define TMR3_CTRL_EXF     6
`define TMR3_CTRL_RCLK    5
`define TMR3_CTRL_SERIAL_TX_CLOCK_SELECT    4
`define TMR3_CTRL_EXEN    3
`define TMR3_CTRL_RUN     2
`define TMR3_CTRL_CSEL    1
`define TMR3_CTRL_CPRL    0
`define TMR3_MODE_DOWN_COUNT_ENABLE    0
`define TMR3_MODE_OE      1
`define TMR3_BITOP_VAL    3
`define TMR3_CNT_MAX      16'hFFFF
`define TMR3_CNT_ZERO     16'h0000
`define TMR3_CNT_ONE      16'h0001
`define TMR3_RESP_OKAY    2'h0
`define TMR3_RESP_SLVERR  2'h2
`endif

//--- logic/tmr3_pkg.sv
// Types shared by the third timer's modules.
package tmr3_pkg;
   typedef enum logic [1:0] {
      st_idle = 2'h1,
      st_resp = 2'h2
   } tmr3_bus_state_type;
endpackage

//--- logic/tmr3_pin_sync.sv
// Two-stage pin synchronisers with falling-edge detection.
`timescale 1ns/1ps
module tmr3_pin_sync #(
   parameter int W = 2
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] level,
   output logic      [W-1:0] fall
);
   // ==========================================================
   // Synchroniser chain per pin
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_pin
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         // Idle pins read high, so reset to one avoids a false edge.
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               s1_reg <= 1'h1;
               s2_reg <= 1'h1;
               s3_reg <= 1'h1;
            end else begin
               s1_reg <= pin_in[i];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
            end
         end
         assign level[i] = s2_reg;
         assign fall[i]  = s3_reg & ~s2_reg;
      end
   endgenerate
endmodule

//--- logic/tmr3_timer.sv
// Third timer/counter with capture, up/down reload, baud and clock-out, AXI4-Lite slave.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "tmr3_regs.svh"
module tmr3_timer (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic [`TMR3_ADDR_W-1:0] awaddr,
   input  wire logic                    awvalid,
   output logic                         awready,
   input  wire logic [31:0]             wdata,
   input  wire logic [3:0]              wstrb,
   input  wire logic                    wvalid,
   output logic                         wready,
   output logic [1:0]                   bresp,
   output logic                         bvalid,
   input  wire logic                    bready,
   input  wire logic [`TMR3_ADDR_W-1:0] araddr,
   input  wire logic                    arvalid,
   output logic                         arready,
   output logic [31:0]                  rdata,
   output logic [1:0]                   rresp,
   output logic                         rvalid,
   input  wire logic                    rready,
   input  wire logic                    count_clockout_pin_in,
   output logic                         count_clockout_pin_out,
   output logic                         count_clockout_pin_oe_n,
   input  wire logic                    trigger_direction_pin_in,
   input  wire logic                    timer_one_overflow,
   output logic                         rx_baud_tick,
   output logic                         tx_baud_tick,
   output logic                         timer_irq
);
   // ==========================================================
   // Declarations
   tmr3_pkg::tmr3_bus_state_type wr_state_reg;
   tmr3_pkg::tmr3_bus_state_type rd_state_reg;
   logic [`TMR3_ADDR_W-1:0] aw_addr_reg;
   logic [7:0]              w_data_reg;
   logic [2:0]              w_bit_reg;
   logic                    w_lane_reg;
   logic                    aw_full_reg;
   logic                    w_full_reg;
   logic                    wr_do;
   logic                    wr_ok;
   logic                    wr_hit;
   logic [9:0]              wr_idx;
   logic                    ctrl_wr;
   logic                    cnt_wr;
   logic                    rld_wr;
   logic [31:0]             rd_data;
   logic                    rd_hit;
   logic [7:0]              timer_three_control_reg;
   logic [7:0]              ctrl_next;
   logic [1:0]              timer_three_mode_reg;
   logic [7:0]              count_low_byte_reg;
   logic [7:0]              count_high_byte_reg;
   logic [7:0]              reload_capture_low_reg;
   logic [7:0]              reload_capture_high_reg;
   logic [15:0]             cnt;
   logic [15:0]             rld;
   logic [15:0]             cnt_next;
   logic                    half_reg;
   logic [1:0]              pin_lvl;
   logic [1:0]              pin_fall;
   logic                    run_bit;
   logic                    counter_select;
   logic                    capture_reload_select;
   logic                    external_trigger_enable;
   logic                    serial_rx_clock_select;
   logic                    serial_tx_clock_select;
   logic                    overflow_flag;
   logic                    external_flag;
   logic                    down_count_enable;
   logic                    clock_output_enable;
   logic                    baud;
   logic                    updown;
   logic                    up_dir;
   logic                    tick;
   logic                    ovf;
   logic                    reload_mode;
   logic                    trig;
   logic                    cap;
   logic                    trig_rl;

   assign run_bit                 = timer_three_control_reg[`TMR3_CTRL_RUN];
   assign counter_select          = timer_three_control_reg[`TMR3_CTRL_CSEL];
   assign capture_reload_select   = timer_three_control_reg[`TMR3_CTRL_CPRL];
   assign external_trigger_enable = timer_three_control_reg[`TMR3_CTRL_EXEN];
   assign serial_rx_clock_select  = timer_three_control_reg[`TMR3_CTRL_RCLK];
   assign serial_tx_clock_select  = timer_three_control_reg[`TMR3_CTRL_SERIAL_TX_CLOCK_SELECT];
   assign overflow_flag           = timer_three_control_reg[`TMR3_CTRL_TF];
   assign external_flag           = timer_three_control_reg[`TMR3_CTRL_EXF];
   assign down_count_enable       = timer_three_mode_reg[`TMR3_MODE_DOWN_COUNT_ENABLE];
   assign clock_output_enable     = timer_three_mode_reg[`TMR3_MODE_OE];

   // ==========================================================
   // Pin synchronisers
   tmr3_pin_sync #(
      .W (2)
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_in  ({trigger_direction_pin_in, count_clockout_pin_in}),
      .level   (pin_lvl),
      .fall    (pin_fall)
   );

   // ==========================================================
   // AXI4-Lite write channel
   assign wr_do   = aw_full_reg & w_full_reg & (wr_state_reg == tmr3_pkg::st_idle);
   assign wr_idx  = aw_addr_reg[`TMR3_ADDR_W-1:2];
   assign wr_hit  = (wr_idx >= `TMR3_IDX_CTRL) && (wr_idx <= `TMR3_IDX_BITOP);
   assign wr_ok   = wr_do & w_lane_reg;
   assign ctrl_wr = wr_ok & ((wr_idx == `TMR3_IDX_CTRL) || (wr_idx == `TMR3_IDX_BITOP));
   assign cnt_wr  = wr_ok & ((wr_idx == `TMR3_IDX_CNT_LO) || (wr_idx == `TMR3_IDX_CNT_HI));
   assign rld_wr  = wr_ok & ((wr_idx == `TMR3_IDX_RLD_LO) || (wr_idx == `TMR3_IDX_RLD_HI));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'h0;
         awready     <= 1'h0;
         aw_addr_reg <= '0;
      end else if (awvalid && awready) begin
         aw_full_reg <= 1'h1;
         awready     <= 1'h0;
         aw_addr_reg <= awaddr;
      end else if (wr_do) begin
         aw_full_reg <= 1'h0;
         awready     <= 1'h1;
      end else if (!aw_full_reg) begin
         awready     <= 1'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_reg <= 1'h0;
         wready     <= 1'h0;
         w_data_reg <= 8'h00;
         w_bit_reg  <= 3'h0;
         w_lane_reg <= 1'h0;
      end else if (wvalid && wready) begin
         w_full_reg <= 1'h1;
         wready     <= 1'h0;
         w_data_reg <= wdata[7:0];
         w_bit_reg  <= wdata[2:0];
         w_lane_reg <= wstrb[0];
      end else if (wr_do) begin
         w_full_reg <= 1'h0;
         wready     <= 1'h1;
      end else if (!w_full_reg) begin
         wready     <= 1'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_reg <= tmr3_pkg::st_idle;
         bvalid       <= 1'h0;
         bresp        <= `TMR3_RESP_OKAY;
      end else begin
         case (wr_state_reg)
            tmr3_pkg::st_idle: begin
               if (wr_do) begin
                  bvalid       <= 1'h1;
                  bresp        <= wr_hit ? `TMR3_RESP_OKAY : `TMR3_RESP_SLVERR;
                  wr_state_reg <= tmr3_pkg::st_resp;
               end
            end
            tmr3_pkg::st_resp: begin
               if (bready) begin
                  bvalid       <= 1'h0;
                  wr_state_reg <= tmr3_pkg::st_idle;
               end
            end
            default: begin
               bvalid       <= 1'h0;
               wr_state_reg <= tmr3_pkg::st_idle;
            end
         endcase
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit  = 1'h1;
      case (araddr[`TMR3_ADDR_W-1:2])
         `TMR3_IDX_CTRL:   rd_data[7:0] = timer_three_control_reg;
         `TMR3_IDX_MODE:   rd_data[1:0] = timer_three_mode_reg;
         `TMR3_IDX_CNT_LO: rd_data[7:0] = count_low_byte_reg;
         `TMR3_IDX_CNT_HI: rd_data[7:0] = count_high_byte_reg;
         `TMR3_IDX_RLD_LO: rd_data[7:0] = reload_capture_low_reg;
         `TMR3_IDX_RLD_HI: rd_data[7:0] = reload_capture_high_reg;
         `TMR3_IDX_BITOP:  rd_data[7:0] = 8'h00;
         default:          rd_hit = 1'h0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_reg <= tmr3_pkg::st_idle;
         arready      <= 1'h0;
         rvalid       <= 1'h0;
         rdata        <= 32'h0000_0000;
         rresp        <= `TMR3_RESP_OKAY;
      end else begin
         case (rd_state_reg)
            tmr3_pkg::st_idle: begin
               if (arvalid && arready) begin
                  arready      <= 1'h0;
                  rvalid       <= 1'h1;
                  rdata        <= rd_data;
                  rresp        <= rd_hit ? `TMR3_RESP_OKAY : `TMR3_RESP_SLVERR;
                  rd_state_reg <= tmr3_pkg::st_resp;
               end else begin
                  arready      <= 1'h1;
               end
            end
            tmr3_pkg::st_resp: begin
               if (rready) begin
                  rvalid       <= 1'h0;
                  arready      <= 1'h1;
                  rd_state_reg <= tmr3_pkg::st_idle;
               end
            end
            default: begin
               rvalid       <= 1'h0;
               rd_state_reg <= tmr3_pkg::st_idle;
            end
         endcase
      end
   end

   // ==========================================================
   // Count engine
   assign cnt    = {count_high_byte_reg, count_low_byte_reg};
   assign rld    = {reload_capture_high_reg, reload_capture_low_reg};
   assign baud   = serial_rx_clock_select | serial_tx_clock_select;
   assign updown = down_count_enable & ~capture_reload_select & ~baud;
   assign up_dir = ~updown | pin_lvl[1];
   assign tick   = run_bit & (clock_output_enable ? half_reg
                                                  : (counter_select ? pin_fall[0] : 1'h1));
   assign ovf    = tick & (up_dir ? (cnt == `TMR3_CNT_MAX) : (cnt == rld));
   assign reload_mode = baud | ~capture_reload_select | clock_output_enable;
   assign trig    = external_trigger_enable & ~baud & ~updown & pin_fall[1];
   assign cap     = trig & capture_reload_select;
   assign trig_rl = trig & ~capture_reload_select;

   always_comb begin
      cnt_next = cnt;
      if (trig_rl) begin
         cnt_next = rld;
      end else if (ovf) begin
         if (!up_dir) begin
            cnt_next = `TMR3_CNT_MAX;
         end else if (reload_mode) begin
            cnt_next = rld;
         end else begin
            cnt_next = `TMR3_CNT_ZERO;
         end
      end else if (tick) begin
         cnt_next = up_dir ? cnt + `TMR3_CNT_ONE : cnt - `TMR3_CNT_ONE;
      end
   end

   // Software writes win over the engine so a loaded value is never lost.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_low_byte_reg  <= 8'h00;
         count_high_byte_reg <= 8'h00;
      end else begin
         count_low_byte_reg  <= cnt_next[7:0];
         count_high_byte_reg <= cnt_next[15:8];
         if (wr_ok && wr_idx == `TMR3_IDX_CNT_LO) begin
            count_low_byte_reg <= w_data_reg;
         end
         if (wr_ok && wr_idx == `TMR3_IDX_CNT_HI) begin
            count_high_byte_reg <= w_data_reg;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reload_capture_low_reg  <= 8'h00;
         reload_capture_high_reg <= 8'h00;
      end else if (cap) begin
         reload_capture_low_reg  <= count_low_byte_reg;
         reload_capture_high_reg <= count_high_byte_reg;
      end else if (wr_ok && wr_idx == `TMR3_IDX_RLD_LO) begin
         reload_capture_low_reg  <= w_data_reg;
      end else if (wr_ok && wr_idx == `TMR3_IDX_RLD_HI) begin
         reload_capture_high_reg <= w_data_reg;
      end
   end

   // ==========================================================
   // Control and mode registers
   always_comb begin
      ctrl_next = timer_three_control_reg;
      if (wr_ok && wr_idx == `TMR3_IDX_CTRL) begin
         ctrl_next = w_data_reg;
      end else if (wr_ok && wr_idx == `TMR3_IDX_BITOP) begin
         ctrl_next[w_bit_reg] = w_data_reg[`TMR3_BITOP_VAL];
      end
   end

   // Hardware set is ORed after the software value so a same-cycle clear never loses it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_three_control_reg <= `TMR3_CTRL_RESET;
      end else begin
         timer_three_control_reg <= ctrl_next;
         timer_three_control_reg[`TMR3_CTRL_TF] <= ctrl_next[`TMR3_CTRL_TF] | (ovf & ~baud);
         timer_three_control_reg[`TMR3_CTRL_EXF] <=
            (ctrl_next[`TMR3_CTRL_EXF] | trig) ^ (ovf & updown);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_three_mode_reg <= `TMR3_MODE_RESET;
      end else if (wr_ok && wr_idx == `TMR3_IDX_MODE) begin
         timer_three_mode_reg <= w_data_reg[1:0];
      end
   end

   // ==========================================================
   // Outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         half_reg                <= 1'h0;
         count_clockout_pin_out  <= 1'h1;
         count_clockout_pin_oe_n <= 1'h1;
      end else begin
         half_reg                <= clock_output_enable & run_bit & ~half_reg;
         count_clockout_pin_oe_n <= ~clock_output_enable;
         if (clock_output_enable && ovf) begin
            count_clockout_pin_out <= ~count_clockout_pin_out;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_baud_tick <= 1'h0;
         tx_baud_tick <= 1'h0;
         timer_irq    <= 1'h0;
      end else begin
         rx_baud_tick <= serial_rx_clock_select ? ovf : timer_one_overflow;
         tx_baud_tick <= serial_tx_clock_select ? ovf : timer_one_overflow;
         timer_irq    <= (overflow_flag & ~clock_output_enable)
                       | (external_flag & ~down_count_enable);
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_ud_wrap;
      ovf && updown && !cnt_wr && !rld_wr;
   endsequence
   sequence s_co_tick;
      clock_output_enable && run_bit && tick;
   endsequence

   a_run_gate: assert property ((!run_bit && !cnt_wr && !trig_rl) |=> $stable(cnt))
      else $error("Count moved while stopped.");
   a_ovf_flag: assert property ((ovf && !baud) |=> overflow_flag)
      else $error("Overflow flag not set.");
   a_baud_reload: assert property ((ovf && baud && !cnt_wr && !rld_wr) |=> cnt == $past(rld))
      else $error("Baud overflow did not reload.");
   a_up_reload: assert property ((s_ud_wrap and up_dir) |=> cnt == $past(rld))
      else $error("Up overflow did not reload.");
   a_down_floor: assert property ((s_ud_wrap and !up_dir) |=> cnt == `TMR3_CNT_MAX)
      else $error("Underflow did not load FFFFh.");
   a_exf_toggle: assert property ((s_ud_wrap and !ctrl_wr) |=>
      external_flag != $past(external_flag))
      else $error("External flag did not toggle.");
   a_cap_copy: assert property (cap |=> rld == $past(cnt))
      else $error("Capture value wrong.");
   a_trig_ignore: assert property ((!external_trigger_enable || baud) |-> !trig)
      else $error("Trigger acted while disabled.");
   a_clk_toggle: assert property ((clock_output_enable && ovf) |=>
      $changed(count_clockout_pin_out))
      else $error("Clock output did not toggle.");
   a_half_rate: assert property ((s_co_tick ##1 (clock_output_enable && run_bit)) |-> !tick)
      else $error("Clock-out ticked on consecutive cycles.");
   a_irq_quiet: assert property ((clock_output_enable && !external_flag) |=> !timer_irq)
      else $error("Interrupt raised in clock-out mode.");
   a_baud_route: assert property ((serial_rx_clock_select && ovf) |=> rx_baud_tick)
      else $error("Receive clock not routed.");
endmodule

//--- sim/tmr3_pins.sv
// Model of the count pin, trigger pin and other timer beside the third timer.
`timescale 1ns/1ps
module tmr3_pins (
   input  wire logic aclk,
   input  wire logic pin_out,
   input  wire logic pin_oe_n,
   output logic      cnt_pin,
   output logic      dir_pin,
   output logic      t1_ovf
);
   logic       drv = 1'b1;
   logic [2:0] t1_div = 3'h0;
   // device owns the pin in clock-out; a pull-up holds it high otherwise.
   assign cnt_pin = pin_oe_n ? drv : pin_out;
   initial begin
      dir_pin = 1'b1;
   end
   // The other timer overflows once every eight cycles.
   always @(posedge aclk) begin
      t1_div <= t1_div + 3'h1;
      t1_ovf <= (t1_div == 3'h7);
   end
   // Pulses last four cycles so the two-stage synchronisers never miss them.
   task automatic pulse(input logic on_dir);
      @(posedge aclk);
      if (on_dir) dir_pin <= 1'b0;
      else drv <= 1'b0;
      repeat (4) @(posedge aclk);
      dir_pin <= 1'b1;
      drv <= 1'b1;
      repeat (4) @(posedge aclk);
   endtask
   task automatic dir(input logic v);
      @(posedge aclk);
      dir_pin <= v;
   endtask
endmodule

//--- sim/tb.sv
// Self-checking bench for the third timer.
`timescale 1ns/1ps
`include "tmr3_regs.svh"
module tb;
   logic [`TMR3_ADDR_W-1:0] awaddr = '0;
   logic [`TMR3_ADDR_W-1:0] araddr = '0;
   logic [31:0] wdata = '0;
   logic [31:0] rdata;
   logic [1:0]  bresp;
   logic [1:0]  rresp;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        arvalid = 1'b0;
   logic        bready = 1'b0;
   logic        rready = 1'b0;
   logic [3:0]  strb = 4'hF;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        cnt_pin, dir_pin, t1_ovf, pin_out, oe_n, tx_tick, rx_tick, irq, v;
   logic [7:0]  d;
   int          num_errors = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          n;
   int          m;
   tmr3_timer DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(strb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .count_clockout_pin_in(cnt_pin), .count_clockout_pin_out(pin_out),
      .count_clockout_pin_oe_n(oe_n), .trigger_direction_pin_in(dir_pin),
      .timer_one_overflow(t1_ovf), .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick),
      .timer_irq(irq));
   tmr3_pins P (.aclk(aclk), .pin_out(pin_out), .pin_oe_n(oe_n), .cnt_pin(cnt_pin),
      .dir_pin(dir_pin), .t1_ovf(t1_ovf));
   // ==========================================
   // Bus and compare tasks
   task automatic wr(input logic [9:0] i, input logic [7:0] x);
      awaddr <= {i, 2'h0};
      wdata <= {24'h0, x};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [9:0] i);
      araddr <= {i, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata[7:0];
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [9:0] i, input logic [7:0] e);
      rd(i);
      chk(16'(d), 16'(e));
   endtask
   task automatic wrap_up();
      if (num_errors == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic s_timer();
      rc(`TMR3_IDX_CTRL, 8'h00);
      rd(10'h0FF);
      chk(16'(rresp), 16'(`TMR3_RESP_SLVERR));
      strb <= 4'h0;
      wr(`TMR3_IDX_RLD_LO, 8'h55);
      strb <= 4'hF;
      rc(`TMR3_IDX_RLD_LO, 8'h00);
      wr(`TMR3_IDX_RLD_LO, 8'h34);
      wr(`TMR3_IDX_RLD_HI, 8'h12);
      wr(`TMR3_IDX_CNT_LO, 8'hFE);
      wr(`TMR3_IDX_CNT_HI, 8'hFF);
      wr(`TMR3_IDX_CTRL, 8'h04);
      repeat (8) @(posedge aclk);
      wr(`TMR3_IDX_BITOP, 8'h02);
      rc(`TMR3_IDX_CTRL, 8'h80);
      chk(16'(irq), 16'h0001);
      rc(`TMR3_IDX_CNT_HI, 8'h12);
      wr(`TMR3_IDX_BITOP, 8'h07);
      rc(`TMR3_IDX_CTRL, 8'h00);
   endtask
   task automatic s_capture();
      wr(`TMR3_IDX_CNT_LO, 8'h78);
      wr(`TMR3_IDX_CNT_HI, 8'h56);
      wr(`TMR3_IDX_CTRL, 8'h09);
      P.pulse(1'b1);
      rc(`TMR3_IDX_RLD_HI, 8'h56);
      rc(`TMR3_IDX_CNT_LO, 8'h78);
      rc(`TMR3_IDX_CTRL, 8'h49);
      chk(16'(irq), 16'h0001);
      wr(`TMR3_IDX_CTRL, 8'h01);
      P.pulse(1'b1);
      rc(`TMR3_IDX_CTRL, 8'h01);
   endtask
   task automatic s_counter();
      wr(`TMR3_IDX_CNT_LO, 8'h00);
      wr(`TMR3_IDX_CTRL, 8'h06);
      for (n = 0; n < 3; n++) P.pulse(1'b0);
      wr(`TMR3_IDX_CTRL, 8'h02);
      P.pulse(1'b0);
      rc(`TMR3_IDX_CNT_LO, 8'h03);
   endtask
   task automatic s_updown();
      wr(`TMR3_IDX_MODE, 8'h01);
      P.dir(1'b0);
      wr(`TMR3_IDX_RLD_LO, 8'h10);
      wr(`TMR3_IDX_RLD_HI, 8'h00);
      wr(`TMR3_IDX_CNT_LO, 8'h11);
      wr(`TMR3_IDX_CNT_HI, 8'h00);
      wr(`TMR3_IDX_CTRL, 8'h04);
      repeat (8) @(posedge aclk);
      wr(`TMR3_IDX_BITOP, 8'h02);
      rc(`TMR3_IDX_CTRL, 8'hC0);
      rc(`TMR3_IDX_CNT_HI, 8'hFF);
      wr(`TMR3_IDX_BITOP, 8'h07);
      rc(`TMR3_IDX_CTRL, 8'h40);
      chk(16'(irq), 16'h0000);
      P.dir(1'b1);
      wr(`TMR3_IDX_CNT_LO, 8'hFE);
      wr(`TMR3_IDX_CNT_HI, 8'hFF);
      wr(`TMR3_IDX_BITOP, 8'h0A);
      repeat (8) @(posedge aclk);
      wr(`TMR3_IDX_BITOP, 8'h02);
      rc(`TMR3_IDX_CNT_HI, 8'h00);
      rc(`TMR3_IDX_CTRL, 8'h80);
      wr(`TMR3_IDX_CTRL, 8'h00);
   endtask
   task automatic s_clkout();
      wr(`TMR3_IDX_MODE, 8'h02);
      wr(`TMR3_IDX_RLD_LO, 8'hFE);
      wr(`TMR3_IDX_RLD_HI, 8'hFF);
      wr(`TMR3_IDX_CNT_LO, 8'hFE);
      wr(`TMR3_IDX_CNT_HI, 8'hFF);
      wr(`TMR3_IDX_CTRL, 8'h04);
      repeat (12) @(posedge aclk);
      chk(16'(oe_n), 16'h0000);
      v = pin_out;
      while (pin_out === v) @(posedge aclk);
      v = pin_out;
      n = 0;
      while (pin_out === v) begin
         @(posedge aclk);
         n++;
      end
      chk(16'(n), 16'h0004);
      chk(16'(irq), 16'h0000);
      wr(`TMR3_IDX_CTRL, 8'h10);
      wr(`TMR3_IDX_BITOP, 8'h0A);
      n = 0;
      m = 0;
      repeat (16) begin
         @(posedge aclk);
         n += tx_tick;
         m += rx_tick;
      end
      chk(16'(n), 16'h0004);
      chk(16'(m), 16'h0002);
      wr(`TMR3_IDX_BITOP, 8'h02);
      rc(`TMR3_IDX_CTRL, 8'h10);
   endtask
   initial begin
      forever #12.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up();
      end
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      s_timer();
      s_capture();
      s_counter();
      s_updown();
      s_clkout();
      wrap_up();
   end
endmodule
